// ### hw/evsf_consts.svh
// offsets, field positions, reset values and widths of the event status flags bank
`ifndef EVSF_CONSTS_SVH
`define EVSF_CONSTS_SVH

// register offsets on the host port, as printed
`define EVSF_ADDR_W          12
`define EVSF_OFS_FLAGS       12'h310
`define EVSF_OFS_BACKUP      12'h311

// flag bit positions
`define EVSF_BIT_ACTIVE      0
`define EVSF_BIT_REACTIVE    1
`define EVSF_BIT_AUX1        2
`define EVSF_BIT_AUX2        3
`define EVSF_BIT_FRESH       4
`define EVSF_BIT_ENGINE      5
`define EVSF_BIT_SUPPLY      7
`define EVSF_BIT_RESET       8

// mirror fields: bits 0..5 copied to 16..21, bit 8 copied to 24
`define EVSF_MIRROR_LO       16
`define EVSF_MIRROR_RESET    24

// widths
`define EVSF_FLAG_W          9
`define EVSF_PULSE_N         4
`define EVSF_SUPPLY_W        2

// reset values
`define EVSF_FLAGS_RST       9'h100
`define EVSF_WORD_RST        32'h01000100
`define EVSF_BACKUP_RST      32'h00000000

`endif

// ### hw/evsf_pkg.sv
// types shared by the event status flags bank
`default_nettype none
package evsf_pkg;
  typedef logic [31:0] evsf_word_t;  // one register word
  typedef logic [11:0] evsf_addr_t;  // host port register offset
  typedef logic [8:0]  evsf_flag_t;  // live event flags, bit 6 unused
endpackage
`default_nettype wire

// ### hw/evsf_edge_capture.sv
// start-of-pulse and supply-change detectors for the event status flags bank
`default_nettype none
`include "evsf_consts.svh"
module evsf_edge_capture (
  // clock and reset
  input  wire logic                        mclk,
  input  wire logic                        nrst,
  // pulse levels from the pulse generators, same clock
  input  wire logic [`EVSF_PULSE_N-1:0]    pulse_lvl,
  // supply status from the analog comparators, asynchronous
  input  wire logic [`EVSF_SUPPLY_W-1:0]   supply_async,
  // one-cycle event pulses
  output logic      [`EVSF_PULSE_N-1:0]    pulse_start,
  output logic                             supply_change
);
  logic [`EVSF_PULSE_N-1:0]  pulse_prev_reg;  // pulse levels one cycle ago
  logic [`EVSF_SUPPLY_W-1:0] sync1_reg;       // first synchroniser stage
  logic [`EVSF_SUPPLY_W-1:0] sync2_reg;       // second synchroniser stage
  logic [`EVSF_SUPPLY_W-1:0] supply_prev_reg; // settled supply status last cycle
  logic [`EVSF_SUPPLY_W-1:0] supply_diff;     // per-bit change

  // per-bit history; the first sync stage feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < `EVSF_PULSE_N; gi++) begin : g_pulse
      always_ff @(posedge mclk) begin
        if (!nrst) begin
          pulse_prev_reg[gi] <= 1'b0;
        end else begin
          pulse_prev_reg[gi] <= pulse_lvl[gi];
        end
      end
      // a pulse starts on its rising level
      assign pulse_start[gi] = pulse_lvl[gi] & ~pulse_prev_reg[gi];
    end
    for (gi = 0; gi < `EVSF_SUPPLY_W; gi++) begin : g_supply
      // no reset here: clearing the history would show a false change when
      // the supply status is not zero at release; the chain needs three
      // reset cycles to fill with the pin's level
      always_ff @(posedge mclk) begin
        sync1_reg[gi]       <= supply_async[gi];
        sync2_reg[gi]       <= sync1_reg[gi];
        supply_prev_reg[gi] <= sync2_reg[gi];
      end
      assign supply_diff[gi] = sync2_reg[gi] ^ supply_prev_reg[gi];
    end
  endgenerate

  // any status bit moving counts as one change event
  assign supply_change = |supply_diff;
endmodule // evsf_edge_capture
`default_nettype wire

// ### hw/evsf_top.sv
// event status flags bank: sticky event flags, clear on read, and backup copy
// What this block does
// - reading the flags register clears every flag
// - bit 0 sets on active pulse start
// - bit 1 sets on reactive pulse start
// - bit 2 sets on first auxiliary pulse
// - bit 3 sets on second auxiliary pulse
// - bit 4 sets when fresh data arrives
// - bit 5 sets when engine pass ends
// - bit 7 sets when supply status changes
// - bit 8 set after reset, reads 0x01000100
// - bits 16-21 and 24 mirror flags
// - flags hold events until read
// - backup loaded with status on each flags register read
`default_nettype none
`include "evsf_consts.svh"
module evsf_top (
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       nrst,
  // metering pulse levels, same clock
  input  wire logic                       active_energy_pulse,
  input  wire logic                       reactive_energy_pulse,
  input  wire logic                       aux1_pulse,
  input  wire logic                       aux2_pulse,
  // compute engine events, one-cycle pulses, same clock
  input  wire logic                       fresh_data,
  input  wire logic                       engine_pass_done,
  // supply status from the comparators, asynchronous
  input  wire logic [`EVSF_SUPPLY_W-1:0]  system_supply_status,
  // register read port from the serial host port decoder
  input  wire logic                       rd_en,
  input  wire evsf_pkg::evsf_addr_t       rd_addr,
  output evsf_pkg::evsf_word_t            rd_data,
  output logic                            rd_valid
);
  // design notes:
  // - all events are taken on mclk; only the supply status is asynchronous
  //   and passes two synchroniser flops before it is compared
  // - a clearing read and a new event in one cycle: the event wins, so it
  //   is reported by the next read instead of being lost
  // - the backup word is the exact word handed to the host, mirrors included,
  //   so a host comparing the two sees only changes since its last read
  // - reading the backup has no side effect; unmapped offsets answer zero
  // - the supply change flag has no mirror copy in the upper half
  // - reset must last three cycles so the supply history matches the pin
  evsf_pkg::evsf_flag_t flags_reg;    // live sticky flags
  evsf_pkg::evsf_flag_t set_vec;      // events arriving this cycle
  evsf_pkg::evsf_word_t status_word;  // flags laid out as the register
  evsf_pkg::evsf_word_t backup_reg;   // copy taken at the last status read
  evsf_pkg::evsf_word_t rd_data_reg;  // read answer
  logic                 rd_valid_reg; // answer strobe
  logic                 status_rd;    // read of the flags register this cycle
  logic [3:0]           pulse_start;  // start-of-pulse events
  logic                 supply_change;// supply status moved

  // edge detectors and supply synchroniser
  evsf_edge_capture u_capture (
    .mclk          (mclk),
    .nrst          (nrst),
    .pulse_lvl     ({aux2_pulse, aux1_pulse, reactive_energy_pulse, active_energy_pulse}),
    .supply_async  (system_supply_status),
    .pulse_start   (pulse_start),
    .supply_change (supply_change)
  );

  // gather this cycle's events into flag positions
  always_comb begin
    set_vec                        = '0;
    set_vec[`EVSF_BIT_ACTIVE]      = pulse_start[0];
    set_vec[`EVSF_BIT_REACTIVE]    = pulse_start[1];
    set_vec[`EVSF_BIT_AUX1]        = pulse_start[2];
    set_vec[`EVSF_BIT_AUX2]        = pulse_start[3];
    set_vec[`EVSF_BIT_FRESH]       = fresh_data;
    set_vec[`EVSF_BIT_ENGINE]      = engine_pass_done;
    set_vec[`EVSF_BIT_SUPPLY]      = supply_change;
  end

  // register layout: low flags, mirror copies, reserved bits zero
  always_comb begin
    status_word                                   = '0;
    status_word[`EVSF_BIT_RESET:0]                = flags_reg;
    status_word[`EVSF_MIRROR_LO +: 6]             = flags_reg[5:0];
    status_word[`EVSF_MIRROR_RESET]               = flags_reg[`EVSF_BIT_RESET];
  end

  assign status_rd = rd_en && (rd_addr == `EVSF_OFS_FLAGS);

  // sticky flags: set by events, cleared by a status read, set wins
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      flags_reg <= `EVSF_FLAGS_RST;  // reset flag raised by reset itself
    end else if (status_rd) begin
      flags_reg <= set_vec;  // clear, but keep events of this very cycle
    end else begin
      flags_reg <= flags_reg | set_vec;  // hold until read
    end
  end

  // backup copy follows every status read so the host can spot changes
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      backup_reg <= `EVSF_BACKUP_RST;
    end else if (status_rd) begin
      backup_reg <= status_word;
    end
  end

  // read answer one cycle after the request; unmapped offsets read zero
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rd_data_reg  <= '0;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= rd_en;
      if (status_rd) begin
        rd_data_reg <= status_word;
      end else if (rd_en && (rd_addr == `EVSF_OFS_BACKUP)) begin
        rd_data_reg <= backup_reg;
      end else if (rd_en) begin
        rd_data_reg <= '0;
      end
    end
  end

  assign rd_data  = rd_data_reg;
  assign rd_valid = rd_valid_reg;

  // checks next to the logic they guard
  AST_CLEAR_ON_READ: assert property (@(posedge mclk) disable iff (!nrst)
    status_rd && (set_vec == '0) |=> (flags_reg == '0))
    else $error("flags not cleared by status read");
  AST_ACTIVE_SET: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(active_energy_pulse) |=> flags_reg[0])
    else $error("active pulse start not flagged");
  AST_REACTIVE_SET: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(reactive_energy_pulse) |=> flags_reg[1])
    else $error("reactive pulse start not flagged");
  AST_AUX1_SET: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(aux1_pulse) |=> flags_reg[2])
    else $error("aux1 pulse start not flagged");
  AST_AUX2_SET: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(aux2_pulse) |=> flags_reg[3])
    else $error("aux2 pulse start not flagged");
  AST_FRESH_SET: assert property (@(posedge mclk) disable iff (!nrst)
    fresh_data |=> flags_reg[4])
    else $error("fresh data not flagged");
  AST_ENGINE_SET: assert property (@(posedge mclk) disable iff (!nrst)
    engine_pass_done |=> flags_reg[5])
    else $error("engine pass not flagged");
  AST_SUPPLY_SET: assert property (@(posedge mclk) disable iff (!nrst)
    ($changed(system_supply_status) && !status_rd ##3 !status_rd) |=> flags_reg[7])
    else $error("supply change not flagged within sync delay");
  AST_RESET_VALUE: assert property (@(posedge mclk)
    $rose(nrst) |-> (status_word == `EVSF_WORD_RST))
    else $error("status word wrong after reset");
  AST_MIRROR: assert property (@(posedge mclk) disable iff (!nrst)
    rd_valid && $past(status_rd) |-> (rd_data[21:16] == rd_data[5:0])
      && (rd_data[24] == rd_data[8]) && (rd_data[15:9] == '0))
    else $error("mirror bits disagree with flags");
  AST_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
    !status_rd |=> ((flags_reg & $past(flags_reg)) == $past(flags_reg)))
    else $error("flag lost without a read");
  AST_BACKUP_LOAD: assert property (@(posedge mclk) disable iff (!nrst)
    status_rd |=> (backup_reg == rd_data) && rd_valid)
    else $error("backup not loaded with status read value");
  AST_SET_WINS: assert property (@(posedge mclk) disable iff (!nrst)
    status_rd && (set_vec != '0) |=> ((flags_reg & $past(set_vec)) == $past(set_vec)))
    else $error("event lost in clearing read");
  // reserved bits of the register word never carry a one
  AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (!nrst)
    (status_word & 32'hfec0fe40) == 32'h00000000)
    else $error("reserved status bit set");
  // every request gets exactly one answer strobe on the next edge
  AST_ONE_ANSWER: assert property (@(posedge mclk) disable iff (!nrst)
    rd_en |=> rd_valid)
    else $error("read not answered");
  AST_NO_SPURIOUS: assert property (@(posedge mclk) disable iff (!nrst)
    !rd_en |=> !rd_valid)
    else $error("answer without a read");
  // the backup only moves on a status read
  AST_BACKUP_QUIET: assert property (@(posedge mclk) disable iff (!nrst)
    !status_rd |=> $stable(backup_reg))
    else $error("backup moved without a status read");
  // offsets outside the two registers answer zero
  AST_UNMAPPED_ZERO: assert property (@(posedge mclk) disable iff (!nrst)
    rd_en && (rd_addr != `EVSF_OFS_FLAGS) && (rd_addr != `EVSF_OFS_BACKUP)
      |=> (rd_data == 32'h00000000))
    else $error("unmapped offset answered nonzero");
  // the supply flag rises only after a detected change
  AST_SUPPLY_CAUSE: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(flags_reg[`EVSF_BIT_SUPPLY]) |-> $past(supply_change))
    else $error("supply flag set without a change");
endmodule // evsf_top
`default_nettype wire

// ### bench/evsf_host_model.sv
// host controller model: issues register reads and watches for status changes
`default_nettype none
`include "evsf_consts.svh"
module evsf_host_model (
  // clock
  input  wire logic                 mclk,
  // read requests from the bench
  input  wire logic                 go,
  input  wire evsf_pkg::evsf_addr_t go_addr,
  // read port towards the device
  output logic                      rd_en,
  output evsf_pkg::evsf_addr_t      rd_addr,
  input  wire logic                 rd_valid,
  input  wire evsf_pkg::evsf_word_t rd_data,
  // backup word differs from the last status word
  output logic                      changed
);
  timeunit 1ns;
  timeprecision 1ps;
  evsf_pkg::evsf_addr_t last_addr;  // offset of the read in flight
  evsf_pkg::evsf_word_t last_stat;  // last status word seen
  // one read per request; an idle address is scrambled so nothing leans on it
  always_ff @(posedge mclk) begin
    rd_en   <= go;
    rd_addr <= go ? go_addr : ~rd_addr;
    if (rd_en) begin
      last_addr <= rd_addr;
    end
  end
  // a backup word unlike the last status word means an event slipped in
  always_ff @(posedge mclk) begin
    if (rd_valid && last_addr == `EVSF_OFS_BACKUP) begin
      changed <= (rd_data != last_stat);
    end else if (rd_valid && last_addr == `EVSF_OFS_FLAGS) begin
      last_stat <= rd_data;
    end
  end
endmodule  // evsf_host_model
`default_nettype wire

// ### bench/event_status_flags_test.sv
// self-checking testbench of the event status flags bank
`default_nettype none
`include "evsf_consts.svh"
module event_status_flags_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, nrst, go, chg, rd_en, rd_valid, fresh, engine;
  logic [3:0] pl;  // pulse levels: active, reactive, aux1, aux2
  logic [1:0] sup;  // supply status
  evsf_pkg::evsf_addr_t go_addr, rd_addr;
  evsf_pkg::evsf_word_t rd_data, expq[$];  // expected read words, oldest first
  int n_errors, n_tests, cyc, i, m;
  evsf_top u_dut (.mclk(mclk), .nrst(nrst), .active_energy_pulse(pl[0]),
    .reactive_energy_pulse(pl[1]), .aux1_pulse(pl[2]), .aux2_pulse(pl[3]),
    .fresh_data(fresh), .engine_pass_done(engine), .system_supply_status(sup),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));
  evsf_host_model u_host (.mclk(mclk), .go(go), .go_addr(go_addr), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data), .changed(chg));
  // clock at 50 MHz
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic end_of_test();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input evsf_pkg::evsf_word_t got, input evsf_pkg::evsf_word_t exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_chg(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one read request; the expected word is noted when the request is made
  task automatic rd(input evsf_pkg::evsf_addr_t a, input evsf_pkg::evsf_word_t e);
    @(posedge mclk);
    go <= 1'b1;
    go_addr <= a;
    expq.push_back(e);
    @(posedge mclk);
    go <= 1'b0;
  endtask
  // watcher: each answer is matched against the oldest note, off the clock edge
  always @(negedge mclk) begin
    if (rd_valid === 1'b1) begin
      if (expq.size() == 0) begin
        check(rd_data, ~rd_data);
      end else begin
        check(rd_data, expq.pop_front());
      end
    end
  end
  // hang guard: the whole run needs well under 2000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    {nrst, go, fresh, engine, pl, sup, go_addr, n_errors, n_tests, cyc} = '0;
    void'($urandom(62258));
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    rd(`EVSF_OFS_FLAGS, 32'h01000100);
    rd(`EVSF_OFS_BACKUP, 32'h01000100);
    rd(`EVSF_OFS_FLAGS, 32'h0);
    rd(`EVSF_OFS_BACKUP, 32'h0);
    $display("reset and clear test done");
    for (i = 0; i < 24; i++) begin
      m = (i < 6) ? (1 << i) : $urandom_range(63, 1);
      @(posedge mclk);
      {engine, fresh, pl} <= m[5:0];
      @(posedge mclk);
      {engine, fresh, pl} <= '0;
      repeat ($urandom_range(4, 0)) @(posedge mclk);
      rd(`EVSF_OFS_FLAGS, {10'h0, m[5:0], 10'h0, m[5:0]});
      rd(`EVSF_OFS_BACKUP, {10'h0, m[5:0], 10'h0, m[5:0]});
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      check_chg(chg, 1'b0);
    end
    $display("event flag test done");
    @(posedge mclk);
    pl <= 4'hf;
    rd(`EVSF_OFS_FLAGS, 32'h000f000f);
    rd(`EVSF_OFS_FLAGS, 32'h0);
    pl <= 4'h0;
    for (i = 0; i < 2; i++) begin
      sup <= sup ^ 2'(1 << i);
      repeat (8) @(posedge mclk);
      rd(`EVSF_OFS_FLAGS, 32'h80);
      rd(`EVSF_OFS_FLAGS, 32'h0);
    end
    $display("held level and supply test done");
    @(posedge mclk);
    go <= 1'b1;
    go_addr <= `EVSF_OFS_FLAGS;
    expq.push_back(32'h0);
    @(posedge mclk);
    go <= 1'b0;
    fresh <= 1'b1;
    @(posedge mclk);
    fresh <= 1'b0;
    rd(`EVSF_OFS_FLAGS, 32'h00100010);
    for (i = 0; i < 6; i++) begin
      m = $urandom_range(4095, 0);
      if (m[11:1] != 11'h188) begin
        rd(12'(m), 32'h0);
      end
    end
    repeat (6) @(posedge mclk);
    $display("same cycle and unmapped test done");
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    rd(`EVSF_OFS_FLAGS, 32'h01000100);
    rd(`EVSF_OFS_BACKUP, 32'h01000100);
    repeat (4) @(posedge mclk);
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule  // event_status_flags_test
`default_nettype wire
